// [core/srh_pkg.sv]
// Purpose: Constants for the host controller of the 512K x 8 asynchronous static memory
// Assumes: 200 MHz host clock, 5 ns period
// Notes:   Times held in their own units, cycle counts derived from them
package srh_pkg;
    localparam int ADDR_W      = 19;
    localparam int DATA_W      = 8;
    localparam int CLK_PS      = 5000;
    // Times in picoseconds unless named otherwise
    localparam int SUPPLY_SETTLE_WAIT_US = 100;
    localparam int WRITE_CYCLE_PS        = 8000;
    localparam int STROBE_WIDTH_PS       = 6000;
    localparam int WRITE_DATA_SETUP_PS   = 4000;
    localparam int WRITE_TO_HIGH_Z_PS    = 4000;
    localparam int READ_ACCESS_PS        = 8000;
    localparam int DRIVE_OFF_PS          = 4000;
    // Least times round up
    localparam int SETTLE_CYC = (SUPPLY_SETTLE_WAIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int WSTROBE_A  = (STROBE_WIDTH_PS + CLK_PS - 1) / CLK_PS;
    localparam int WSTROBE_B  = (WRITE_DATA_SETUP_PS + WRITE_TO_HIGH_Z_PS + CLK_PS - 1) / CLK_PS;
    localparam int WSTROBE_CYC = (WSTROBE_A > WSTROBE_B) ? WSTROBE_A : WSTROBE_B;
    localparam int WSETUP_CYC  = (WRITE_DATA_SETUP_PS + CLK_PS - 1) / CLK_PS;
    localparam int READ_CYC    = (READ_ACCESS_PS + CLK_PS - 1) / CLK_PS + 1;
    localparam int TURN_CYC    = (DRIVE_OFF_PS + CLK_PS - 1) / CLK_PS;
    localparam int WCYCLE_CYC  = (WRITE_CYCLE_PS + CLK_PS - 1) / CLK_PS;
    typedef enum logic [2:0] {
        SRH_SETTLE,
        SRH_IDLE,
        SRH_RD,
        SRH_TURN,
        SRH_WR,
        SRH_WEND
    } srh_state_t;
endpackage : srh_pkg

// [core/srh_sync.sv]
// Purpose: Two-flop synchroniser for the read data lines
// Assumes: Data lines are asynchronous to clk_i
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module srh_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce_i) begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end
    assign q_o = sync_ff;
endmodule // srh_sync
`default_nettype wire

// [core/srh_host.sv]
// Purpose: Host controller driving a 512K x 8 asynchronous static memory by its pins
// Assumes: One request at a time, user holds request until ready
// Notes:   All pin outputs come straight from flip-flops; strobes timed in whole cycles
`timescale 1ns/10ps
`default_nettype none
// Operation
// - A write lasts only while select and store strobe are both low, and either rising ends it.
// - The host times write data setup and hold to the rising strobe that ends the write.
// - The host waits at least 100 us after power is stable before its first access.
// - A strobe-timed write with drive enable low lasts at least data setup plus write-to-float time.
// - The host must not drive the data lines while the memory may still be driving them.
module srh_host #(
    parameter int SETTLE_CYCLES = srh_pkg::SETTLE_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        clk_en_i,
    input  wire logic                        req_i,
    input  wire logic                        req_write_i,
    input  wire logic [srh_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [srh_pkg::DATA_W-1:0]  req_wdata_i,
    output logic                             ready_o,
    output logic                             rvalid_o,
    output logic      [srh_pkg::DATA_W-1:0]  rdata_o,
    output logic      [srh_pkg::ADDR_W-1:0]  location_inputs_o,
    output logic                             chip_select_n_o,
    output logic                             drive_enable_n_o,
    output logic                             store_strobe_n_o,
    input  wire logic [srh_pkg::DATA_W-1:0]  data_lines_i,
    output logic      [srh_pkg::DATA_W-1:0]  data_lines_o,
    output logic                             data_lines_oe_o
);
    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1) + 1;

    srh_pkg::srh_state_t state_ff;
    logic [CNT_W-1:0]           cnt_ff;
    logic                       ready_ff;
    logic                       rvalid_ff;
    logic [srh_pkg::DATA_W-1:0] rdata_ff;
    logic [srh_pkg::ADDR_W-1:0] addr_ff;
    logic [srh_pkg::DATA_W-1:0] wdata_ff;
    logic                       cs_n_ff;
    logic                       oe_n_ff;
    logic                       we_n_ff;
    logic                       doe_ff;
    logic [srh_pkg::DATA_W-1:0] din_sync;
    logic                       take;

    srh_sync #(
        .W (srh_pkg::DATA_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (clk_en_i),
        .d_i     (data_lines_i),
        .q_o     (din_sync)
    );

    assign take = ready_ff && req_i;

    // Sequencer and strobes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= srh_pkg::SRH_SETTLE;
            cnt_ff   <= '0;
            ready_ff <= 1'b0;
            cs_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            doe_ff   <= 1'b0;
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else if (clk_en_i) begin
            unique case (state_ff)
                srh_pkg::SRH_SETTLE: begin
                    // Power-up wait before any access
                    if (cnt_ff == CNT_W'(SETTLE_CYCLES - 1)) begin
                        cnt_ff   <= '0;
                        ready_ff <= 1'b1;
                        state_ff <= srh_pkg::SRH_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                srh_pkg::SRH_IDLE: begin
                    // Deselected between accesses keeps the memory in standby
                    cs_n_ff <= 1'b1;
                    if (take) begin
                        ready_ff <= 1'b0;
                        addr_ff  <= req_addr_i;
                        wdata_ff <= req_wdata_i;
                        cs_n_ff  <= 1'b0;
                        cnt_ff   <= '0;
                        if (req_write_i) begin
                            // Drive enable stays high so the memory never drives during a write
                            oe_n_ff  <= 1'b1;
                            state_ff <= srh_pkg::SRH_WR;
                        end else begin
                            oe_n_ff  <= 1'b0;
                            we_n_ff  <= 1'b1;
                            state_ff <= srh_pkg::SRH_RD;
                        end
                    end
                end
                srh_pkg::SRH_RD: begin
                    // Access time plus two sync stages
                    if (cnt_ff == CNT_W'(srh_pkg::READ_CYC + 1)) begin
                        cs_n_ff  <= 1'b1;
                        oe_n_ff  <= 1'b1;
                        cnt_ff   <= '0;
                        state_ff <= srh_pkg::SRH_TURN;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                srh_pkg::SRH_TURN: begin
                    // Let the memory release the lines before the host may drive
                    if (cnt_ff == CNT_W'(srh_pkg::TURN_CYC - 1)) begin
                        ready_ff <= 1'b1;
                        state_ff <= srh_pkg::SRH_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                srh_pkg::SRH_WR: begin
                    if (cnt_ff == '0) begin
                        // Address settled one cycle before strobe falls
                        we_n_ff <= 1'b0;
                        doe_ff  <= 1'b1;
                        cnt_ff  <= cnt_ff + 1'b1;
                    end else if (cnt_ff == CNT_W'(srh_pkg::WSTROBE_CYC)) begin
                        // Strobe and select rise together; data held one more cycle
                        we_n_ff  <= 1'b1;
                        cs_n_ff  <= 1'b1;
                        cnt_ff   <= '0;
                        state_ff <= srh_pkg::SRH_WEND;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                srh_pkg::SRH_WEND: begin
                    // Hold data past the ending edge
                    doe_ff   <= 1'b0;
                    ready_ff <= 1'b1;
                    state_ff <= srh_pkg::SRH_IDLE;
                end
                default: begin
                    state_ff <= srh_pkg::SRH_SETTLE;
                end
            endcase
        end
    end

    // Read capture
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
        end else if (clk_en_i) begin
            rvalid_ff <= 1'b0;
            if (state_ff == srh_pkg::SRH_RD && cnt_ff == CNT_W'(srh_pkg::READ_CYC + 1)) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= din_sync;
            end
        end
    end

    assign ready_o           = ready_ff;
    assign rvalid_o          = rvalid_ff;
    assign rdata_o           = rdata_ff;
    assign location_inputs_o = addr_ff;
    assign chip_select_n_o   = cs_n_ff;
    assign drive_enable_n_o  = oe_n_ff;
    assign store_strobe_n_o  = we_n_ff;
    assign data_lines_o      = wdata_ff;
    assign data_lines_oe_o   = doe_ff;

    // Assertions
    a_no_drive_clash: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        doe_ff |-> oe_n_ff) else $error("Host drives data while memory output enabled");
    a_write_overlap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !we_n_ff |-> !cs_n_ff) else $error("Store strobe low without select");
    a_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && $fell(we_n_ff)) |-> !we_n_ff [*2]) else $error("Write strobe too short");
    a_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && $rose(we_n_ff)) |-> doe_ff) else $error("Write data dropped at ending edge");
    a_settle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == srh_pkg::SRH_SETTLE) |-> (cs_n_ff && !ready_ff)) else $error("Access during power-up wait");
    a_joint_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && $rose(we_n_ff)) |-> $rose(cs_n_ff)) else $error("Select and strobe did not rise together");
    a_read_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !oe_n_ff |-> we_n_ff) else $error("Read with store strobe low");
    a_read_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rvalid_ff) |-> $past(state_ff) == srh_pkg::SRH_RD) else $error("Read data without read");
    a_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!cs_n_ff && !$past(cs_n_ff)) |-> $stable(addr_ff)) else $error("Address moved during access");

    // Frozen cycles repeat samples, so the strobe width, data hold, joint rise and turn gap checks gate on clk_en_i
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == srh_pkg::SRH_IDLE) |-> (cs_n_ff && oe_n_ff && we_n_ff && !doe_ff))
        else $error("Idle pins active");
    a_write_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == srh_pkg::SRH_WR) |-> (!cs_n_ff && oe_n_ff)) else $error("Write without select");
    a_read_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == srh_pkg::SRH_RD) |-> (!cs_n_ff && !oe_n_ff && we_n_ff && !doe_ff))
        else $error("Read pins wrong");
    a_turn_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && $rose(oe_n_ff)) |=> !doe_ff) else $error("Host drove right after read");
    // Ready must not rise before the full power-up count
    a_settle_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($rose(ready_ff) && $past(state_ff) == srh_pkg::SRH_SETTLE) |-> $past(cnt_ff) == CNT_W'(SETTLE_CYCLES - 1))
        else $error("Power-up wait cut short");
    a_wdata_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !we_n_ff |-> (doe_ff && $stable(wdata_ff) && $stable(addr_ff))) else $error("Write data moved");
    a_wend_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == srh_pkg::SRH_WEND) |-> (cs_n_ff && we_n_ff && doe_ff)) else $error("Write end order wrong");
endmodule // srh_host
`default_nettype wire

// [sim/srh_mem_model.sv]
// Purpose: Behavioural asynchronous byte memory facing the host pins
// Assumes: Access time 2 ns prompt or 7 ns slow, picked by slow_i
// Notes:   Unwritten bytes read as the inverted low address byte
`timescale 1ns/10ps
`default_nettype none
module srh_mem_model (
    input  wire logic [18:0] addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        slow_i,
    input  wire logic [7:0]  bus_i,
    output logic      [7:0]  data_o,
    output logic             drive_o
);
    logic [7:0] mem [int];
    logic       rd_en;
    logic       en_fast;
    logic       en_slow;
    // Deselected means standby, nothing driven
    assign rd_en = !cs_n_i && !oe_n_i && we_n_i;
    assign #2 en_fast = rd_en;
    assign #7 en_slow = rd_en;
    assign drive_o = slow_i ? en_slow : en_fast;
    // Latch through the overlap so the last value before the rising edge sticks
    always @(addr_i, bus_i, cs_n_i, we_n_i) begin
        if (!cs_n_i && !we_n_i)
            mem[int'(addr_i)] = bus_i;
    end
    always @(addr_i, cs_n_i, oe_n_i, we_n_i) begin
        data_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : ~addr_i[7:0];
    end
endmodule // srh_mem_model
`default_nettype wire

// [sim/srh_host_tb.sv]
// Purpose: Self-checking bench for the memory host controller
// Assumes: Settle shortened to 8 cycles
// Notes:   Inputs change on falling edges; outputs sampled there
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module srh_host_tb;
    logic clk_i = 0, rst_n_i = 0, clk_en_i = 1, req_i = 0, req_write_i = 0, slow = 0;
    logic [18:0] req_addr_i = '0, addr;
    logic [7:0]  req_wdata_i = '0, rdata, dl_o, m_d, last = '0;
    logic        ready, rvalid, cs_n, oe_n, we_n, dl_oe, m_drv, we_q = 1;
    int          error_cnt = 0, compares = 0;
    wire  [7:0]  bus = dl_oe ? dl_o : (m_drv ? m_d : ~last);
    always #2.5 clk_i = ~clk_i;
    srh_host #(.SETTLE_CYCLES(8)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .ready_o(ready), .rvalid_o(rvalid), .rdata_o(rdata), .location_inputs_o(addr),
        .chip_select_n_o(cs_n), .drive_enable_n_o(oe_n), .store_strobe_n_o(we_n),
        .data_lines_i(bus), .data_lines_o(dl_o), .data_lines_oe_o(dl_oe));
    srh_mem_model mem (.addr_i(addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .slow_i(slow), .bus_i(bus), .data_o(m_d), .drive_o(m_drv));
    // Released lines show the inverse so a stale value never passes
    always @(posedge clk_i) if (dl_oe || m_drv) last <= bus;
    always @(negedge clk_i) begin
        if (rst_n_i) begin
            if (m_drv && dl_oe) `CHK(1'b0, 1'b1)
            if (!we_n) `CHK(oe_n, 1'b1)
            if (we_n && !we_q) `CHK(dl_oe, 1'b1)
        end
        we_q <= we_n;
    end
    task automatic end_of_test;
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        do @(negedge clk_i); while (ready !== 1'b1 && ++n < 60);
        if (ready !== 1'b1) error_cnt++;
        req_i = 1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_i = 0;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] e);
        int n;
        xfer(0, a, '0);
        n = 0;
        while (rvalid !== 1'b1 && n < 30) begin
            @(negedge clk_i);
            n++;
        end
        if (rvalid !== 1'b1) error_cnt++;
        `CHK(rdata, e)
    endtask
    task automatic t_settle;
        req_i = 1;
        repeat (6) begin
            @(negedge clk_i);
            `CHK({ready, cs_n}, 2'b01)
        end
        req_i = 0;
    endtask
    task automatic t_rw;
        logic [18:0] a[4] = '{19'h0, 19'h1, 19'h7ffff, 19'h40000};
        logic [7:0]  d[4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
        foreach (a[i]) xfer(1, a[i], d[i]);
        foreach (a[i]) rd(a[i], d[i]);
        rd(19'h12345, 8'hba);
    endtask
    task automatic t_slow;
        slow = 1;
        xfer(1, 19'h40000, 8'h3c);
        rd(19'h40000, 8'h3c);
        rd(19'h7ffff, 8'hff);
        slow = 0;
    endtask
    task automatic t_freeze;
        xfer(0, 19'h1, '0);
        clk_en_i = 0;
        repeat (10) begin
            @(negedge clk_i);
            `CHK({cs_n, oe_n, rvalid}, 3'b000)
        end
        clk_en_i = 1;
        repeat (8) @(negedge clk_i);
        `CHK(rdata, 8'h5a)
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1;
        t_settle();
        t_rw();
        t_slow();
        t_freeze();
        end_of_test();
    end
    initial begin
        #20000;
        error_cnt++;
        end_of_test();
    end
endmodule // srh_host_tb
`default_nettype wire
